// ### spfc_defines.svh
// Summary of operation
// (R1) ready interrupt requested while enable bit clear
// (R2) rww program sets busy flag, blocks section
// (R3) busy cleared by re-enable or buffer load
// (R4) signature read: load reads row, store ignored
// (R5) re-enable after completion, refused while busy
// (R6) re-enable during buffer fill discards buffer
// (R7) boot lock set from r0 via store
// (R8) load in window reads lock or fuse
// (R9) page write from buffer to z page
// (R10) page erase of z page
// (R11) processor stalled for no_read_while_write_section programming
// (R12) enable alone fills buffer word from r1:r0
// (R13) enable clears on store, timeout, or completion
// (R14) only permitted command patterns take effect
// (R15) software keeps one store outstanding
// (R16) lock byte six bits, unused read one
// (R17) lock bits return to one only by chip erase; the code also reloads them to ones on reset
// (R18) lock mode 2 blocks external programming, fuses
// (R19) lock mode 3 blocks programming and verify
// (R20) app modes 2 and 3 refuse stores
// (R21) app modes 3 and 4 refuse boot loads
// (R22) app modes 3 and 4 suppress interrupts
// (R23) software keeps pointer bit zero low
// (R24) boot field mirrors application protection modes
// (R25) programming time is a busy count
// (R26) refused accesses leave memory, no stall
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH

// register byte offsets
`define SPFC_OFS_CTRL_STATUS 12'h000
`define SPFC_OFS_LOCK_BYTE 12'h004
`define SPFC_OFS_CONFIG 12'h008

// control/status field positions
`define SPFC_BIT_IRQ_EN 7
`define SPFC_BIT_BUSY 6
`define SPFC_BIT_SIGNATURE_READ_BIT 5
`define SPFC_BIT_REEN 4
`define SPFC_BIT_BOOT_LOCK_SET_BIT 3
`define SPFC_BIT_PAGE_WRITE_BIT 2
`define SPFC_BIT_PAGE_ERASE_BIT 1
`define SPFC_BIT_SELF_PROGRAM_ENABLE 0

// permitted low five bit command patterns
`define SPFC_CMD_REEN 5'h11
`define SPFC_CMD_BOOT_LOCK_SET_BIT 5'h09
`define SPFC_CMD_PAGE_WRITE_BIT 5'h05
`define SPFC_CMD_PAGE_ERASE_BIT 5'h03
`define SPFC_CMD_FILL 5'h01

// config field positions
`define SPFC_BIT_CHIP_ERASE 0
`define SPFC_BIT_BOOTSZ_LO 1
`define SPFC_BIT_BOOTSZ_HI 2
`define SPFC_BIT_VEC_BOOT 3

// reset values
`define SPFC_LOCK_RESET 6'h3F
`define SPFC_BOOTSZ_RESET 2'h0

// arming windows in clock cycles
`define SPFC_STORE_WINDOW 3'h4
`define SPFC_LOAD_LAST 3'h2

// section limits in words
`define SPFC_NO_READ_WHILE_WRITE_SECTION_START 16'hF000

// timing
`define SPFC_CLK_MHZ 25
`define SPFC_PROG_TIME_US 4000

`endif

// ### spfc_pkg.sv
`default_nettype none
package spfc_pkg;
    typedef enum logic [1:0] {
        SPFC_IDLE,
        SPFC_ARMED,
        SPFC_BUSY
    } spfc_state_e;

    typedef logic [16:0] spfc_zptr_t;
endpackage : spfc_pkg
`default_nettype wire

// ### spfc_ctrl.sv
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spfc_defines.svh"

module spfc_ctrl #(
    parameter int PROG_TIME_US = `SPFC_PROG_TIME_US,
    parameter int PROG_CYCLES = PROG_TIME_US * `SPFC_CLK_MHZ
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor store/load instructions
    input wire logic spm_req,
    input wire logic lpm_req,
    input wire spfc_pkg::spfc_zptr_t zptr,
    input wire logic [7:0] r0,
    input wire logic [7:0] r1,
    input wire logic pc_in_boot,
    input wire logic global_irq_en,
    output logic spm_refused,
    output logic lpm_special,
    output logic lpm_refused,
    output logic [7:0] lpm_data,
    output logic cpu_stall,
    output logic ready_irq,
    output logic irq_suppress,
    output logic rww_blocked,
    // fuse and signature sources
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] sig_byte,
    // flash array side
    output logic prog_start,
    output logic prog_erase,
    output logic [8:0] prog_page,
    output logic prog_done,
    input wire logic [6:0] buf_rd_addr,
    output logic [15:0] buf_rd_data,
    // lock protection state
    output logic ext_prog_block,
    output logic ext_verify_block,
    output logic fuse_locked,
    output logic boot_lock_locked
);
    import spfc_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    spfc_state_e state_q;
    logic [5:0] cmd_q;
    logic irq_en_q;
    logic busy_q;
    logic [2:0] win_q;
    logic [19:0] prog_cnt_q;
    logic [5:0] lock_q;
    logic [1:0] bootsz_q;
    logic vec_boot_q;
    logic stall_q;
    logic prog_write_q;
    logic [15:0] buf_mem [0:127];
    logic [127:0] buf_vld_q;

    // ==========================================================
    // apb decode
    // ==========================================================
    wire logic wr_en = psel & penable & pwrite & pstrb[0];
    // read data is loaded in the setup cycle so that it stands at the access edge
    wire logic rd_setup = psel & ~penable & ~pwrite;
    wire logic hit_cs = (paddr == `SPFC_OFS_CTRL_STATUS);
    wire logic hit_lock = (paddr == `SPFC_OFS_LOCK_BYTE);
    wire logic hit_cfg = (paddr == `SPFC_OFS_CONFIG);
    wire logic hit_any = hit_cs | hit_lock | hit_cfg;
    wire logic cs_wr = wr_en & hit_cs;
    wire logic lock_wr = wr_en & hit_lock;
    wire logic cfg_wr = wr_en & hit_cfg;
    wire logic chip_erase = cfg_wr & pwdata[`SPFC_BIT_CHIP_ERASE];

    wire logic [4:0] wr_low = pwdata[4:0];
    wire logic wr_signature_read_bit = pwdata[`SPFC_BIT_SIGNATURE_READ_BIT];
    wire logic pat_ok = (wr_low == `SPFC_CMD_REEN) | (wr_low == `SPFC_CMD_BOOT_LOCK_SET_BIT)
                      | (wr_low == `SPFC_CMD_PAGE_WRITE_BIT) | (wr_low == `SPFC_CMD_PAGE_ERASE_BIT)
                      | (wr_low == `SPFC_CMD_FILL);
    // signature read only rides on the plain enable pattern
    wire logic cmd_ok = pat_ok & (~wr_signature_read_bit | (wr_low == `SPFC_CMD_FILL)); // R14
    wire logic not_busy = (state_q != SPFC_BUSY);
    wire logic arm = cs_wr & cmd_ok & not_busy; // R5
    // a re-enable write while the buffer holds data drops the fill
    wire logic fill_abort = arm & (wr_low == `SPFC_CMD_REEN) & (|buf_vld_q); // R6

    wire logic [7:0] cs_val = {irq_en_q, busy_q, cmd_q};
    wire logic [7:0] lock_val = {2'b11, lock_q}; // R16
    wire logic [7:0] cfg_val = {4'h0, vec_boot_q, bootsz_q, 1'b0};
    wire logic [7:0] rd_byte = hit_cs ? cs_val : hit_lock ? lock_val : hit_cfg ? cfg_val : 8'h00;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    // ==========================================================
    // section and protection decode
    // ==========================================================
    wire logic [15:0] word_addr = zptr[16:1];
    wire logic [8:0] z_page = zptr[16:8];
    wire logic [6:0] z_word = zptr[7:1];
    logic [15:0] boot_start;
    always_comb begin
        case (bootsz_q)
            2'h3: boot_start = 16'hFE00;
            2'h2: boot_start = 16'hFC00;
            2'h1: boot_start = 16'hF800;
            default: boot_start = 16'hF000;
        endcase
    end
    wire logic tgt_boot = (word_addr >= boot_start);
    wire logic tgt_rww = (word_addr < `SPFC_NO_READ_WHILE_WRITE_SECTION_START);

    wire logic mem_lo = lock_q[0];
    wire logic mem_hi = lock_q[1];
    wire logic app_lo = lock_q[2];
    wire logic app_hi = lock_q[3];
    wire logic boot_lo = lock_q[4];
    wire logic boot_hi = lock_q[5];

    // store writes refused in modes 2 and 3 (low bit programmed)
    wire logic spm_blocked = tgt_boot ? ~boot_lo : ~app_lo; // R20 R24
    // cross-section loads refused in modes 3 and 4 (high bit programmed)
    wire logic lpm_blocked = (~tgt_boot & pc_in_boot & ~app_hi) // R21
                           | (tgt_boot & ~pc_in_boot & ~boot_hi) // R24
                           | (tgt_rww & busy_q); // R2

    assign irq_suppress = (~app_hi & vec_boot_q & ~pc_in_boot) // R22
                        | (~boot_hi & ~vec_boot_q & pc_in_boot);
    assign ext_prog_block = ~mem_lo; // R18
    assign fuse_locked = ~mem_lo; // R18
    assign ext_verify_block = ~mem_lo & ~mem_hi; // R19
    assign boot_lock_locked = ~mem_lo & ~mem_hi; // R19

    assign ready_irq = irq_en_q & global_irq_en & ~cmd_q[`SPFC_BIT_SELF_PROGRAM_ENABLE]; // R1
    assign rww_blocked = busy_q; // R2
    assign cpu_stall = stall_q;

    // ==========================================================
    // store execution decode
    // ==========================================================
    wire logic spm_go = spm_req & (state_q == SPFC_ARMED);
    wire logic is_sig = cmd_q[`SPFC_BIT_SIGNATURE_READ_BIT];
    wire logic is_prog = ~is_sig & (cmd_q[`SPFC_BIT_PAGE_WRITE_BIT] | cmd_q[`SPFC_BIT_PAGE_ERASE_BIT]);
    wire logic is_blb = ~is_sig & cmd_q[`SPFC_BIT_BOOT_LOCK_SET_BIT];
    wire logic is_reen = ~is_sig & cmd_q[`SPFC_BIT_REEN];
    wire logic is_fill = (cmd_q[4:0] == `SPFC_CMD_FILL) & ~is_sig;
    wire logic prog_go = spm_go & is_prog & ~spm_blocked; // R9 R10
    wire logic prog_ref = spm_go & is_prog & spm_blocked; // R26
    wire logic fill_go = spm_go & is_fill; // R12
    wire logic blb_go = spm_go & is_blb; // R7
    wire logic reen_go = spm_go & is_reen; // R5
    wire logic win_end = (state_q == SPFC_ARMED) & ~spm_req & (win_q == 3'h1);
    wire logic prog_end = (state_q == SPFC_BUSY) & (prog_cnt_q == 20'h0);
    wire logic lpm_win = (state_q == SPFC_ARMED) & (win_q >= `SPFC_LOAD_LAST);
    wire logic lpm_sig = lpm_req & lpm_win & is_sig; // R4
    wire logic lpm_fuse = lpm_req & lpm_win & is_blb; // R8

    // ==========================================================
    // sequencer
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SPFC_IDLE;
            cmd_q <= 6'h00;
            win_q <= 3'h0;
            prog_cnt_q <= 20'h0;
            stall_q <= 1'b0;
            prog_write_q <= 1'b0;
        end else begin
            case (state_q)
                SPFC_IDLE: begin
                    if (arm) begin
                        state_q <= SPFC_ARMED;
                        cmd_q <= {wr_signature_read_bit, wr_low};
                        win_q <= `SPFC_STORE_WINDOW;
                    end
                end
                SPFC_ARMED: begin
                    if (prog_go) begin
                        state_q <= SPFC_BUSY; // R13
                        prog_cnt_q <= 20'(PROG_CYCLES - 1); // R25
                        stall_q <= ~tgt_rww; // R11
                        prog_write_q <= cmd_q[`SPFC_BIT_PAGE_WRITE_BIT];
                    end else if (spm_go | win_end) begin
                        state_q <= SPFC_IDLE; // R13
                        cmd_q <= 6'h00;
                    end else if (arm) begin
                        cmd_q <= {wr_signature_read_bit, wr_low};
                        win_q <= `SPFC_STORE_WINDOW;
                    end else begin
                        win_q <= win_q - 3'h1;
                    end
                end
                SPFC_BUSY: begin
                    if (prog_end) begin
                        state_q <= SPFC_IDLE; // R25
                        cmd_q <= 6'h00;
                        stall_q <= 1'b0;
                    end else begin
                        prog_cnt_q <= prog_cnt_q - 20'h1;
                    end
                end
                default: begin
                    state_q <= SPFC_IDLE;
                    cmd_q <= 6'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // busy flag, interrupt enable, configuration
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (prog_go & tgt_rww) begin
            busy_q <= 1'b1; // R2
        end else if (reen_go | fill_go) begin
            busy_q <= 1'b0; // R3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= 1'b0;
            bootsz_q <= `SPFC_BOOTSZ_RESET;
            vec_boot_q <= 1'b0;
        end else begin
            if (cs_wr) begin
                irq_en_q <= pwdata[`SPFC_BIT_IRQ_EN];
            end
            if (cfg_wr) begin
                bootsz_q <= pwdata[`SPFC_BIT_BOOTSZ_HI:`SPFC_BIT_BOOTSZ_LO];
                vec_boot_q <= pwdata[`SPFC_BIT_VEC_BOOT];
            end
        end
    end

    // ==========================================================
    // lock byte: bits only program to zero, erase restores ones
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= `SPFC_LOCK_RESET;
        end else if (chip_erase) begin
            lock_q <= `SPFC_LOCK_RESET; // R17
        end else if (blb_go) begin
            lock_q <= lock_q & {r0[5:2], 2'b11}; // R7 R17
        end else if (lock_wr) begin
            lock_q <= lock_q & pwdata[5:0]; // R17
        end
    end

    // ==========================================================
    // temporary page buffer
    // ==========================================================
    always_ff @(posedge pclk) begin
        if (fill_go) begin
            buf_mem[z_word] <= {r1, r0}; // R12
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_vld_q <= 128'h0;
        end else if (fill_abort | (prog_end & prog_write_q)) begin
            buf_vld_q <= 128'h0; // R6
        end else if (fill_go) begin
            buf_vld_q[z_word] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_rd_data <= 16'hFFFF;
        end else begin
            buf_rd_data <= buf_vld_q[buf_rd_addr] ? buf_mem[buf_rd_addr] : 16'hFFFF;
        end
    end

    // ==========================================================
    // registered outputs
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            lpm_data <= 8'h00;
            lpm_special <= 1'b0;
            lpm_refused <= 1'b0;
            spm_refused <= 1'b0;
            prog_start <= 1'b0;
            prog_erase <= 1'b0;
            prog_page <= 9'h000;
            prog_done <= 1'b0;
        end else begin
            prdata <= rd_setup ? {24'h0, rd_byte} : 32'h0;
            lpm_special <= lpm_sig | lpm_fuse;
            lpm_refused <= lpm_req & ~(lpm_sig | lpm_fuse) & lpm_blocked; // R26
            spm_refused <= prog_ref; // R26
            prog_start <= prog_go;
            prog_done <= prog_end;
            if (lpm_sig) begin
                lpm_data <= sig_byte; // R4
            end else if (lpm_fuse) begin
                lpm_data <= zptr[0] ? fuse_low : lock_val; // R8
            end
            if (prog_go) begin
                prog_erase <= cmd_q[`SPFC_BIT_PAGE_ERASE_BIT]; // R10
                prog_page <= z_page; // R9
            end
        end
    end
endmodule : spfc_ctrl
`default_nettype wire

// ### spfc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker of the control block
module spfc_checker #(
    parameter int PROG_CYCLES = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // processor side
    input wire logic lpm_req,
    input wire spfc_pkg::spfc_zptr_t zptr,
    input wire logic global_irq_en,
    input wire logic spm_refused,
    input wire logic lpm_special,
    input wire logic lpm_refused,
    input wire logic cpu_stall,
    input wire logic ready_irq,
    input wire logic rww_blocked,
    // flash side and lock state
    input wire logic prog_start,
    input wire logic prog_done,
    input wire logic ext_prog_block,
    input wire logic ext_verify_block,
    input wire logic fuse_locked,
    input wire logic boot_lock_locked
);
    import spfc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ====
    // sequences and assertions
    sequence s_run;
        prog_start ##[1:40] prog_done;
    endsequence
    a_irq_gate: assert property ((!global_irq_en || cpu_stall) |-> !ready_irq)
        else $error("ready irq while gated");
    a_run_ends: assert property (prog_start |-> s_run)
        else $error("programming never done");
    a_stall_hold: assert property (prog_start && cpu_stall |-> cpu_stall [*3])
        else $error("stall dropped early");
    a_stall_ends: assert property (prog_done |-> ##[0:2] !cpu_stall)
        else $error("stall held after done");
    a_busy_set: assert property (prog_start && !cpu_stall |-> rww_blocked)
        else $error("busy flag missing");
    a_busy_load: assert property (rww_blocked && lpm_req && zptr[16:13] != 4'hF |=> lpm_refused)
        else $error("busy section load served");
    a_refuse_quiet: assert property (spm_refused |-> !cpu_stall && !prog_start)
        else $error("refused store started work");
    a_lock_class: assert property (ext_prog_block == fuse_locked && ext_verify_block == boot_lock_locked)
        else $error("lock outputs disagree");
    a_load_pair: assert property (lpm_special || lpm_refused |-> $past(lpm_req) && !(lpm_special && lpm_refused))
        else $error("load answer without load");
endmodule : spfc_checker
bind spfc_ctrl spfc_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn),
    .lpm_req(lpm_req), .zptr(zptr), .global_irq_en(global_irq_en), .spm_refused(spm_refused),
    .lpm_special(lpm_special), .lpm_refused(lpm_refused), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
    .rww_blocked(rww_blocked), .prog_start(prog_start), .prog_done(prog_done),
    .ext_prog_block(ext_prog_block), .ext_verify_block(ext_verify_block), .fuse_locked(fuse_locked),
    .boot_lock_locked(boot_lock_locked));
`default_nettype wire

// ### spfc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// processor issuing store and load instructions
module spfc_cpu_model (
    // clock
    input wire logic pclk,
    // instruction side
    output logic spm_req,
    output logic lpm_req,
    output spfc_pkg::spfc_zptr_t zptr,
    output logic [7:0] r0,
    output logic [7:0] r1
);
    import spfc_pkg::*;
    initial begin
        {spm_req, lpm_req, zptr, r0, r1} = '0;
    end
    // returns only after its own instruction, so one store at a time
    task automatic store(input spfc_zptr_t z, input logic [15:0] d, input int gap);
        repeat (gap + 1) @(posedge pclk);
        spm_req <= 1'b1;
        zptr <= {z[16:1], 1'b0};
        {r1, r0} <= d;
        @(posedge pclk);
        spm_req <= 1'b0;
        zptr <= ~z;
        {r1, r0} <= ~d;
    endtask : store
    task automatic load(input spfc_zptr_t z, input int gap);
        repeat (gap + 1) @(posedge pclk);
        lpm_req <= 1'b1;
        zptr <= z;
        @(posedge pclk);
        lpm_req <= 1'b0;
        zptr <= ~z;
    endtask : load
endmodule : spfc_cpu_model
`default_nettype wire

// ### tb_self_program_flash_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "spfc_defines.svh"
module tb_self_program_flash_control;
    import spfc_pkg::*;
    localparam logic [11:0] CT = `SPFC_OFS_CTRL_STATUS;
    localparam logic [11:0] LK = `SPFC_OFS_LOCK_BYTE;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, spm_req, lpm_req, pc_in_boot;
    logic global_irq_en, spm_refused, lpm_special, lpm_refused, cpu_stall, ready_irq, rww_blocked;
    logic prog_start, prog_erase, prog_done, ext_prog_block, ext_verify_block, fuse_locked;
    logic boot_lock_locked, irq_suppress, err_q, ok;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [7:0] r0, r1, lpm_data, fuse_low, sig_byte, lock_m;
    logic [8:0] prog_page;
    logic [6:0] buf_rd_addr;
    logic [15:0] buf_rd_data, w;
    spfc_zptr_t zptr, z;
    int fails, tests_run, cyc;
    int buf_m [128];
    logic [7:0] bad [4] = '{8'h07, 8'h1F, 8'h0B, 8'h02};
    spfc_ctrl #(.PROG_CYCLES(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .spm_req(spm_req), .lpm_req(lpm_req), .zptr(zptr), .r0(r0), .r1(r1),
        .pc_in_boot(pc_in_boot), .global_irq_en(global_irq_en), .spm_refused(spm_refused),
        .lpm_special(lpm_special), .lpm_refused(lpm_refused), .lpm_data(lpm_data), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .irq_suppress(irq_suppress), .rww_blocked(rww_blocked), .fuse_low(fuse_low),
        .sig_byte(sig_byte), .prog_start(prog_start), .prog_erase(prog_erase), .prog_page(prog_page),
        .prog_done(prog_done), .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data),
        .ext_prog_block(ext_prog_block), .ext_verify_block(ext_verify_block), .fuse_locked(fuse_locked),
        .boot_lock_locked(boot_lock_locked));
    spfc_cpu_model cpu (.pclk(pclk), .spm_req(spm_req), .lpm_req(lpm_req), .zptr(zptr), .r0(r0), .r1(r1));
    // ====
    // tasks
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // read data and error are taken at the access edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err_q = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), {24'h0, e}, rd);
    endtask : rdchk
    task automatic bufchk(input logic [6:0] a);
        buf_rd_addr <= a;
        repeat (2) @(posedge pclk);
        #1 chk("buffer", 32'(buf_m[a]), {16'h0, buf_rd_data});
    endtask : bufchk
    task automatic ldchk(input spfc_zptr_t a, input logic [7:0] e);
        cpu.load(a, 0);
        #1 chk("load", 32'(e), 32'(lpm_data));
        chk("special", 1, 32'(lpm_special));
    endtask : ldchk
    task automatic await(ref logic s, input int n);
        ok = 1'b0;
        for (int i = 0; i < n && ok !== 1'b1; i++) begin
            #1 ok = s;
            if (ok !== 1'b1) begin
                @(posedge pclk);
            end
        end
        chk("event", 1, 32'(ok));
    endtask : await
    task automatic progchk(input logic [8:0] pg, input logic er);
        await(prog_start, 6);
        chk("page", 32'(pg), 32'(prog_page));
        chk("kind", 32'(er), 32'(prog_erase));
    endtask : progchk
    // ====
    // clock, timeout and scenarios
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, pc_in_boot, global_irq_en, paddr, pwdata, buf_rd_addr} = '0;
        pstrb = 4'hF;
        z = 17'($urandom(11));
        fuse_low = 8'($urandom);
        sig_byte = 8'($urandom);
        lock_m = 8'hFF;
        foreach (buf_m[i]) buf_m[i] = 'hFFFF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(CT, 8'h00);
        rdchk(LK, lock_m);
        apb(1'b1, 12'h00C, 8'h00);
        chk("slave error", 1, 32'(err_q));
        for (int i = 0; i < 3; i++) begin
            z = 17'($urandom);
            w = 16'($urandom);
            apb(1'b1, CT, {3'h0, `SPFC_CMD_FILL});
            cpu.store(z, w, i);
            buf_m[z[7:1]] = w;
            rdchk(CT, 8'h00);
            bufchk(z[7:1]);
        end
        apb(1'b1, CT, {3'h0, `SPFC_CMD_FILL});
        cpu.store(z ^ 17'h2, ~w, 4);
        bufchk(z[7:1] ^ 7'h1);
        foreach (bad[i]) begin
            apb(1'b1, CT, bad[i]);
            rdchk(CT, 8'h00);
        end
        bufchk(z[7:1]);
        apb(1'b1, CT, 8'h21);
        ldchk(z, sig_byte);
        apb(1'b1, CT, {3'h0, `SPFC_CMD_REEN});
        foreach (buf_m[i]) buf_m[i] = 'hFFFF;
        bufchk(z[7:1]);
        apb(1'b1, CT, {3'h0, `SPFC_CMD_PAGE_ERASE_BIT});
        cpu.store(17'h00A00, 16'h0000, 1);
        progchk(9'h00A, 1'b1);
        apb(1'b1, CT, {3'h0, `SPFC_CMD_REEN});
        rdchk(CT, 8'h43);
        await(prog_done, 30);
        rdchk(CT, 8'h40);
        cpu.load(17'h00A00, 0);
        #1 chk("blocked", 1, 32'(lpm_refused));
        apb(1'b1, CT, {3'h0, `SPFC_CMD_REEN});
        cpu.store(17'h0, 16'h0000, 0);
        rdchk(CT, 8'h00);
        apb(1'b1, CT, {3'h0, `SPFC_CMD_PAGE_WRITE_BIT});
        cpu.store(17'h1E100, 16'h0000, 2);
        progchk(9'h1E1, 1'b0);
        chk("stall", 1, 32'(cpu_stall));
        await(prog_done, 30);
        @(posedge pclk);
        global_irq_en <= 1'b1;
        apb(1'b1, CT, 8'h80);
        #1 chk("irq", 1, 32'(ready_irq));
        apb(1'b1, CT, 8'h81);
        #1 chk("irq", 0, 32'(ready_irq));
        repeat (5) @(posedge pclk);
        #1 chk("irq", 1, 32'(ready_irq));
        apb(1'b1, CT, {3'h0, `SPFC_CMD_BOOT_LOCK_SET_BIT});
        cpu.store(17'h0, 16'hFFFB, 0);
        lock_m = lock_m & 8'hFB;
        rdchk(LK, lock_m);
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, CT, {3'h0, `SPFC_CMD_BOOT_LOCK_SET_BIT});
            ldchk(17'(j), (j == 1) ? fuse_low : lock_m);
        end
        apb(1'b1, CT, {3'h0, `SPFC_CMD_PAGE_ERASE_BIT});
        cpu.store(17'h00400, 16'h0000, 0);
        await(spm_refused, 4);
        rdchk(CT, 8'h00);
        apb(1'b1, LK, 8'hFE);
        #1 chk("prog block", 1, 32'(ext_prog_block));
        chk("fuse lock", 1, 32'(fuse_locked));
        chk("verify block", 0, 32'(ext_verify_block));
        apb(1'b1, LK, 8'hFD);
        #1 chk("verify block", 1, 32'(ext_verify_block));
        chk("boot lock lock", 1, 32'(boot_lock_locked));
        apb(1'b1, LK, 8'hFF);
        rdchk(LK, 8'hF8);
        apb(1'b1, LK, 8'hF7);
        apb(1'b1, 12'h008, 8'h08);
        pc_in_boot <= 1'b1;
        cpu.load(17'h00400, 0);
        #1 chk("cross load", 1, 32'(lpm_refused));
        chk("irq gate", 0, 32'(irq_suppress));
        @(posedge pclk);
        pc_in_boot <= 1'b0;
        #1 chk("irq gate", 1, 32'(irq_suppress));
        apb(1'b1, 12'h008, 8'h01);
        rdchk(LK, 8'hFF);
        stop_test();
    end
endmodule : tb_self_program_flash_control
`default_nettype wire
